/* rtl/osz_defs.svh */
/*
 * Offsets, field positions, reset values and key codes of the
 * execute-only zone option block.
 * Assumes a Wishbone slave with 32-bit words, one option byte per word.
 */
`ifndef OSZ_DEFS_SVH
`define OSZ_DEFS_SVH

// Word indices of the option bytes and the status register; byte address is four times the index
`define OSZ_KEY_LO_IDX      30'h1ffff780
`define OSZ_KEY_LO_INV_IDX  30'h1ffff781
`define OSZ_KEY_HI_IDX      30'h1ffff782
`define OSZ_KEY_HI_INV_IDX  30'h1ffff783
`define OSZ_DBG_LO_IDX      30'h1ffff788
`define OSZ_DBG_LO_INV_IDX  30'h1ffff789
`define OSZ_DBG_HI_IDX      30'h1ffff78a
`define OSZ_DBG_HI_INV_IDX  30'h1ffff78b
`define OSZ_MASK0_IDX       30'h1ffff78c
`define OSZ_STAT_IDX        30'h1ffff7a0

// Option window: upper index bits, last slot, unmapped gap
`define OSZ_WIN_HI          25'h0ffffbc
`define OSZ_SLOT_LAST       5'h1b
`define OSZ_GAP_LO          5'h04
`define OSZ_GAP_HI          5'h07
`define OSZ_SLOTS           28
`define OSZ_MASK_BYTES      8

// Values
`define OSZ_ERASED          8'hff
`define OSZ_ZONE_KEY        16'h0914
`define OSZ_DBG_KEY         16'h2021

// Status register fields
`define OSZ_ST_ZONE         0
`define OSZ_ST_SWD_OFF      1
`define OSZ_ST_ZONE_BAD     2
`define OSZ_ST_DBG_BAD      3
`define OSZ_ST_REFUSED      4

`endif

/* rtl/osz_pkg.sv */
/*
 * Types shared by the execute-only zone option block.
 * Assumes osz_defs.svh supplies the numeric constants.
 */
package osz_pkg;
   typedef logic [7:0]  osz_byte_t;
   typedef logic [63:0] osz_mask_t;
   typedef enum logic {OSZ_LOAD, OSZ_RUN} osz_phase_e;
endpackage

/* rtl/osz_top.sv */
/*
 * Execute-only flash zone option block: one-time option bytes behind a
 * Wishbone slave, reload with complement checks, fetch-only policing.
 * Assumes flash access requests come from logic on ref_clk, por_n only
 * at power-up, and rst_n as the system reset that reloads options.
 */
// Function
// - Mask bit n governs flash page n, for pages 0 to 63.
// - A zero mask bit puts its page in the execute-only zone.
// - A one mask bit leaves its page unrestricted.
// - Zone pages allow only processor instruction fetches.
// - Any other read of a zone page requests a main-area mass erase.
// - Zone settings apply only when the assembled commit key is 0914.
// - Every option byte pairs with its inverse; pairs checked at reload.
// - A pair reading all ones on both bytes skips the check.
// - Debug lockout key 2021 disables the serial wire debug port.
// - Option changes act only after a system reset reload.
// - An option byte is writable only while still all ones; no erase.
`timescale 1ns/100ps
`include "osz_defs.svh"

module osz_top (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        por_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        acc_valid,
   input  wire logic [5:0]  acc_page,
   input  wire logic        acc_read,
   input  wire logic        acc_fetch,
   input  wire logic        acc_cpu,
   output logic             acc_grant,
   output logic             acc_deny,
   output logic             mass_erase,
   output logic             swd_disable,
   output logic             zone_active
);

   osz_pkg::osz_byte_t  otp [0:`OSZ_SLOTS-1];
   osz_pkg::osz_phase_e phase;
   osz_pkg::osz_mask_t  mask_act;
   logic                zone_bad;
   logic                dbg_bad;
   logic                refused;
   logic [29:0]         widx;
   logic                req;
   logic                otp_hit;
   logic [4:0]          slot;
   logic                wr_otp;
   logic                wr_ok;
   logic                next_zone_en;
   logic                next_swd_off;
   logic                next_zone_bad;
   logic                next_dbg_bad;
   osz_pkg::osz_mask_t  next_mask;
   logic                in_zone;

   // Slot of an option byte index inside the option window
   function automatic logic [4:0] slot_of(input logic [29:0] idx);
      return idx[4:0];
   endfunction

   // Pair is good when complementary, or when both still erased
   function automatic logic pair_ok(input osz_pkg::osz_byte_t b,
                                    input osz_pkg::osz_byte_t nb);
      return (b == ~nb) || (b == `OSZ_ERASED && nb == `OSZ_ERASED);
   endfunction

   // Bus decode
   assign widx    = wb_adr_i[31:2];
   assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign slot    = widx[4:0];
   assign otp_hit = (widx[29:5] == `OSZ_WIN_HI) && (slot <= `OSZ_SLOT_LAST)
                    && !(slot >= `OSZ_GAP_LO && slot <= `OSZ_GAP_HI);
   assign wr_otp  = req && wb_we_i && wb_sel_i[0] && otp_hit;
   assign wr_ok   = wr_otp && (otp[slot] == `OSZ_ERASED);

   // One-time storage: survives system reset, bits only programmed once
   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         for (int i = 0; i < `OSZ_SLOTS; i++) begin
            otp[i] <= `OSZ_ERASED;
         end
      end else if (wr_ok) begin
         otp[slot] <= wb_dat_i[7:0];
      end
   end

   // Wishbone answer one cycle after the request; reads of options give zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= 32'h0000_0000;
         if (req && !wb_we_i && widx == `OSZ_STAT_IDX) begin
            wb_dat_o[`OSZ_ST_ZONE]    <= zone_active;
            wb_dat_o[`OSZ_ST_SWD_OFF] <= swd_disable;
            wb_dat_o[`OSZ_ST_ZONE_BAD]<= zone_bad;
            wb_dat_o[`OSZ_ST_DBG_BAD] <= dbg_bad;
            wb_dat_o[`OSZ_ST_REFUSED] <= refused;
         end
      end
   end

   // Sticky flag of refused option writes; a new refusal beats the clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         refused <= 1'b0;
      end else if (wr_otp && !wr_ok) begin
         refused <= 1'b1;
      end else if (req && wb_we_i && wb_sel_i[0] && widx == `OSZ_STAT_IDX
                   && wb_dat_i[`OSZ_ST_REFUSED]) begin
         refused <= 1'b0;
      end
   end

   // Settings that the reload would produce from the stored bytes
   always_comb begin
      logic [15:0] zkey;
      logic [15:0] dkey;
      logic        mask_ok;
      zkey    = {otp[slot_of(`OSZ_KEY_HI_IDX)], otp[slot_of(`OSZ_KEY_LO_IDX)]};
      dkey    = {otp[slot_of(`OSZ_DBG_HI_IDX)], otp[slot_of(`OSZ_DBG_LO_IDX)]};
      mask_ok = 1'b1;
      next_mask = '1;
      for (int i = 0; i < `OSZ_MASK_BYTES; i++) begin
         next_mask[i*8 +: 8] = otp[slot_of(`OSZ_MASK0_IDX) + 5'(2*i)];
         mask_ok = mask_ok && pair_ok(otp[slot_of(`OSZ_MASK0_IDX) + 5'(2*i)],
                                      otp[slot_of(`OSZ_MASK0_IDX) + 5'(2*i+1)]);
      end
      next_zone_bad = !mask_ok
         || !pair_ok(otp[slot_of(`OSZ_KEY_LO_IDX)], otp[slot_of(`OSZ_KEY_LO_INV_IDX)])
         || !pair_ok(otp[slot_of(`OSZ_KEY_HI_IDX)], otp[slot_of(`OSZ_KEY_HI_INV_IDX)]);
      next_dbg_bad =
            !pair_ok(otp[slot_of(`OSZ_DBG_LO_IDX)], otp[slot_of(`OSZ_DBG_LO_INV_IDX)])
         || !pair_ok(otp[slot_of(`OSZ_DBG_HI_IDX)], otp[slot_of(`OSZ_DBG_HI_INV_IDX)]);
      next_zone_en = (zkey == `OSZ_ZONE_KEY) && !next_zone_bad;
      next_swd_off = (dkey == `OSZ_DBG_KEY) && !next_dbg_bad;
   end

   // Reload once after system reset, then hold the active settings
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase       <= osz_pkg::OSZ_LOAD;
         mask_act    <= '1;
         zone_active <= 1'b0;
         swd_disable <= 1'b0;
         zone_bad    <= 1'b0;
         dbg_bad     <= 1'b0;
      end else if (phase == osz_pkg::OSZ_LOAD) begin
         phase       <= osz_pkg::OSZ_RUN;
         mask_act    <= next_zone_en ? next_mask : '1;
         zone_active <= next_zone_en;
         swd_disable <= next_swd_off;
         zone_bad    <= next_zone_bad;
         dbg_bad     <= next_dbg_bad;
      end
   end

   // Page is protected when the zone is live and its mask bit is zero
   assign in_zone = zone_active && !mask_act[acc_page];

   // Access policing: fetch from the core only; other reads erase
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_grant  <= 1'b0;
         acc_deny   <= 1'b0;
         mass_erase <= 1'b0;
      end else begin
         acc_grant  <= acc_valid && phase == osz_pkg::OSZ_RUN
                       && (!in_zone || (acc_fetch && acc_cpu));
         acc_deny   <= acc_valid && (phase != osz_pkg::OSZ_RUN
                       || (in_zone && !(acc_fetch && acc_cpu)));
         mass_erase <= acc_valid && phase == osz_pkg::OSZ_RUN && in_zone
                       && acc_read && !(acc_fetch && acc_cpu);
      end
   end

   // Checks
   property p_erase;
      @(posedge ref_clk) disable iff (!rst_n)
      acc_valid && phase == osz_pkg::OSZ_RUN && zone_active && !mask_act[acc_page]
      && acc_read && !acc_fetch |=> mass_erase && acc_deny && !acc_grant;
   endproperty
   a_erase: assert property (p_erase) else $error("zone read without erase");

   property p_fetch;
      @(posedge ref_clk) disable iff (!rst_n)
      acc_valid && phase == osz_pkg::OSZ_RUN && acc_fetch && acc_cpu
      |=> acc_grant && !mass_erase;
   endproperty
   a_fetch: assert property (p_fetch) else $error("core fetch refused");

   property p_outside;
      @(posedge ref_clk) disable iff (!rst_n)
      acc_valid && phase == osz_pkg::OSZ_RUN && mask_act[acc_page] |=> acc_grant;
   endproperty
   a_outside: assert property (p_outside) else $error("open page refused");

   property p_zone_write;
      @(posedge ref_clk) disable iff (!rst_n)
      acc_valid && phase == osz_pkg::OSZ_RUN && zone_active && !mask_act[acc_page]
      && !acc_read && !acc_fetch |=> acc_deny && !mass_erase;
   endproperty
   a_zone_write: assert property (p_zone_write) else $error("zone write passed");

   property p_key;
      @(posedge ref_clk) disable iff (!rst_n)
      phase == osz_pkg::OSZ_LOAD && {otp[slot_of(`OSZ_KEY_HI_IDX)],
      otp[slot_of(`OSZ_KEY_LO_IDX)]} != `OSZ_ZONE_KEY |=> !zone_active && mask_act == '1;
   endproperty
   a_key: assert property (p_key) else $error("zone live without key");

   property p_swd;
      @(posedge ref_clk) disable iff (!rst_n)
      phase == osz_pkg::OSZ_LOAD && {otp[slot_of(`OSZ_DBG_HI_IDX)],
      otp[slot_of(`OSZ_DBG_LO_IDX)]} == `OSZ_DBG_KEY && !next_dbg_bad
      |=> swd_disable [*4];
   endproperty
   a_swd: assert property (p_swd) else $error("debug not locked");

   property p_bad_pair;
      @(posedge ref_clk) disable iff (!rst_n)
      phase == osz_pkg::OSZ_LOAD && otp[slot_of(`OSZ_KEY_LO_IDX)] != `OSZ_ERASED
      && otp[slot_of(`OSZ_KEY_LO_IDX)] != ~otp[slot_of(`OSZ_KEY_LO_INV_IDX)]
      |=> zone_bad && !zone_active;
   endproperty
   a_bad_pair: assert property (p_bad_pair) else $error("bad pair accepted");

   property p_erased_skip;
      @(posedge ref_clk) disable iff (!rst_n)
      phase == osz_pkg::OSZ_LOAD && otp[slot_of(`OSZ_DBG_LO_IDX)] == `OSZ_ERASED
      && otp[slot_of(`OSZ_DBG_LO_INV_IDX)] == `OSZ_ERASED
      && otp[slot_of(`OSZ_DBG_HI_IDX)] == `OSZ_ERASED
      && otp[slot_of(`OSZ_DBG_HI_INV_IDX)] == `OSZ_ERASED |=> !dbg_bad;
   endproperty
   a_erased_skip: assert property (p_erased_skip) else $error("erased pair flagged");

   property p_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      phase == osz_pkg::OSZ_RUN |=> $stable(zone_active) && $stable(mask_act)
                                    && $stable(swd_disable);
   endproperty
   a_hold: assert property (p_hold) else $error("settings moved without reset");

   // Refused flag is cleared by system reset, so both resets gate this check
   property p_once;
      @(posedge ref_clk) disable iff (!por_n || !rst_n)
      wr_otp && otp[slot] != `OSZ_ERASED |=> otp[$past(slot)] == $past(otp[slot]) && refused;
   endproperty
   a_once: assert property (p_once) else $error("programmed byte rewritten");

   // An accepted option write leaves the live protection untouched
   property p_wr_quiet;
      @(posedge ref_clk) disable iff (!rst_n)
      wr_ok && phase == osz_pkg::OSZ_RUN |=> $stable(zone_active) && $stable(mask_act)
                                          && $stable(swd_disable);
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("write took effect");

   // A failed zone pair keeps the zone off and every page open
   property p_bad_off;
      @(posedge ref_clk) disable iff (!rst_n)
      zone_bad |-> !zone_active && mask_act == '1;
   endproperty
   a_bad_off: assert property (p_bad_off) else $error("bad zone still live");

   // Nothing is granted before the reload has produced settings
   property p_load_deny;
      @(posedge ref_clk) disable iff (!rst_n)
      acc_valid && phase == osz_pkg::OSZ_LOAD |=> acc_deny && !acc_grant && !mass_erase;
   endproperty
   a_load_deny: assert property (p_load_deny) else $error("access during reload");

   // Every request gets exactly one of grant or deny
   property p_one_answer;
      @(posedge ref_clk) disable iff (!rst_n)
      acc_valid |=> acc_grant ^ acc_deny;
   endproperty
   a_one_answer: assert property (p_one_answer) else $error("access answer unclear");

   // Mask byte zero lands on pages 0 to 7 in order when the zone commits
   property p_mask_map;
      @(posedge ref_clk) disable iff (!rst_n)
      phase == osz_pkg::OSZ_LOAD && next_zone_en
      |=> mask_act[7:0] == $past(otp[slot_of(`OSZ_MASK0_IDX)]);
   endproperty
   a_mask_map: assert property (p_mask_map) else $error("mask byte misplaced");

   c_erase: cover property (@(posedge ref_clk) disable iff (!rst_n) mass_erase);
   c_lock:  cover property (@(posedge ref_clk) disable iff (!rst_n) swd_disable);
   c_zone:  cover property (@(posedge ref_clk) disable iff (!rst_n)
                            zone_active && acc_grant);
   c_refuse: cover property (@(posedge ref_clk) disable iff (!rst_n) refused);
   c_commit: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(zone_active));

endmodule

/* bench/osz_cpu_model.sv */
/* Processor-side flash access source for the zone block.
   Assumes the bench calls access() and all timing is on ref_clk. */
`timescale 1ns/100ps
module osz_cpu_model (
   input  wire logic       ref_clk,
   input  wire logic       acc_grant,
   input  wire logic       acc_deny,
   input  wire logic       mass_erase,
   output logic            acc_valid,
   output logic      [5:0] acc_page,
   output logic            acc_read,
   output logic            acc_fetch,
   output logic            acc_cpu
);
   // Idle at time zero
   initial begin
      {acc_valid, acc_cpu, acc_fetch, acc_read, acc_page} = 10'h000;
   end

   // One request, answer taken a cycle later; idle qualifiers scrambled
   task automatic access(input logic [8:0] req, output logic [2:0] ans);
      @(posedge ref_clk);
      {acc_cpu, acc_fetch, acc_read, acc_page} <= req;
      acc_valid <= 1'b1;
      @(posedge ref_clk);
      acc_valid <= 1'b0;
      {acc_cpu, acc_fetch, acc_read, acc_page} <= ~req;
      #1 ans = {acc_grant, acc_deny, mass_erase};
   endtask
endmodule

/* bench/tb.sv */
/* Self-checking bench of the zone option block.
   Assumes osz_top as u_dut and osz_cpu_model as the flash requester. */
`timescale 1ns/100ps
`include "osz_defs.svh"
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin fail_count++; \
   $display("Error %s expected %h seen %h", n, e, s); end end
module tb;
   logic        ref_clk, rst_n, por_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        acc_valid, acc_read, acc_fetch, acc_cpu;
   logic        acc_grant, acc_deny, mass_erase, swd_disable, zone_active;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
   logic [3:0]  wb_sel_i;
   logic [5:0]  acc_page;
   logic [2:0]  a;
   logic [15:0] seed;
   int          fail_count, checked;

   osz_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .acc_valid(acc_valid), .acc_page(acc_page), .acc_read(acc_read),
      .acc_fetch(acc_fetch), .acc_cpu(acc_cpu), .acc_grant(acc_grant),
      .acc_deny(acc_deny), .mass_erase(mass_erase), .swd_disable(swd_disable),
      .zone_active(zone_active));
   osz_cpu_model u_cpu (.ref_clk(ref_clk), .acc_grant(acc_grant), .acc_deny(acc_deny),
      .mass_erase(mass_erase), .acc_valid(acc_valid), .acc_page(acc_page),
      .acc_read(acc_read), .acc_fetch(acc_fetch), .acc_cpu(acc_cpu));

   // 125 MHz clock
   always #4 ref_clk = ~ref_clk;

   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Expected {grant, deny, erase} for a request
   function automatic logic [2:0] exp_acc(logic [8:0] r, logic on, logic [63:0] m);
      logic z;
      z = on && !m[r[5:0]] && !(r[8] && r[7]);
      return {!z, z, z && r[6]};
   endfunction

   // Classic Wishbone single cycle, bounded wait for ack
   task automatic wb(input logic we, input logic [29:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h000000, d};
      wb_sel_i <= 4'h1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (n >= 20) fail_count++;
   endtask

   // Option byte followed by its inverse
   task automatic opt(input logic [29:0] idx, input logic [7:0] v);
      wb(1'b1, idx, v);
      wb(1'b1, idx + 30'h1, ~v);
   endtask

   // System reset, with power-on reset when p is set
   task automatic rst(input logic p);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      por_n <= !p;
      repeat (2) @(posedge ref_clk);
      {rst_n, por_n} <= 2'b11;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   // Random requests against the expected policy
   task automatic rnd(input logic on, input logic [63:0] m);
      repeat (40) begin
         seed = lfsr(seed);
         u_cpu.access(seed[8:0], a);
         `CHK("access", exp_acc(seed[8:0], on, m), a)
      end
   endtask

   task automatic conclude;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Watchdog
   initial begin
      #100000;
      fail_count++;
      conclude;
   end

   // Main sequence
   initial begin
      ref_clk = 1'b0;
      {rst_n, por_n, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h00;
      {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
      seed = 16'h002a;
      repeat (12) @(posedge ref_clk);
      {rst_n, por_n} <= 2'b11;
      repeat (3) @(posedge ref_clk);
      wb(1'b0, `OSZ_STAT_IDX, 8'h00);
      `CHK("status", 32'h00000000, q)
      rnd(1'b0, '1);
      opt(`OSZ_MASK0_IDX, 8'h5a);
      opt(`OSZ_DBG_LO_IDX, 8'h21);
      opt(`OSZ_DBG_HI_IDX, 8'h20);
      `CHK("swd", 1'b0, swd_disable)
      rst(1'b0);
      `CHK("swd", 1'b1, swd_disable)
      `CHK("zone", 1'b0, zone_active)
      rnd(1'b0, '1);
      opt(`OSZ_KEY_LO_IDX, 8'h14);
      opt(`OSZ_KEY_HI_IDX, 8'h09);
      wb(1'b1, `OSZ_KEY_LO_IDX, 8'h00);
      wb(1'b0, `OSZ_STAT_IDX, 8'h00);
      `CHK("refused", 1'b1, q[`OSZ_ST_REFUSED])
      wb(1'b1, `OSZ_STAT_IDX, 8'h10);
      wb(1'b0, `OSZ_STAT_IDX, 8'h00);
      `CHK("refused clear", 1'b0, q[`OSZ_ST_REFUSED])
      `CHK("zone", 1'b0, zone_active)
      rst(1'b0);
      `CHK("zone", 1'b1, zone_active)
      rnd(1'b1, {56'hffffffffffffff, 8'h5a});
      u_cpu.access(9'h100, a);
      `CHK("zone write", 3'b010, a)
      u_cpu.access(9'h1c0, a);
      `CHK("zone fetch", 3'b100, a)
      rst(1'b1);
      wb(1'b1, `OSZ_KEY_LO_IDX, 8'h14);
      wb(1'b1, `OSZ_KEY_LO_INV_IDX, 8'h00);
      opt(`OSZ_KEY_HI_IDX, 8'h09);
      opt(`OSZ_MASK0_IDX, 8'h00);
      opt(`OSZ_DBG_LO_IDX, 8'h21);
      wb(1'b1, `OSZ_DBG_HI_IDX, 8'h20);
      wb(1'b1, `OSZ_DBG_HI_INV_IDX, 8'h00);
      rst(1'b0);
      wb(1'b0, `OSZ_STAT_IDX, 8'h00);
      `CHK("pair errors", 4'hc, q[3:0])
      u_cpu.access(9'h040, a);
      `CHK("bad zone", 3'b100, a)
      conclude;
   end
endmodule
